// ---- test_usb_control_endpoint_zero.sv ----
`include "uze_defines.svh"
module test_usb_control_endpoint_zero;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [5:0] ev_rx = 6'h01;
   localparam logic [5:0] ev_good = 6'h02;
   localparam logic [5:0] ev_pop = 6'h04;
   localparam logic [5:0] ev_ack = 6'h08;
   localparam logic [5:0] ev_end = 6'h10;
   localparam logic [5:0] ev_err = 6'h20;
   logic MCLK = 1'h0;
   logic RESET_N = 1'h0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'h0;
   logic avs_write = 1'h0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   logic [5:0] ev = 6'h00;
   logic [7:0] rx_data = 8'h00;
   logic [7:0] tx_data;
   logic stall, tx_ready, rx_ready;
   logic irq_pin;
   logic [4:0] level, maxp;
   logic [31:0] exp_q[$];
   logic [31:0] msk_q[$];
   logic [7:0] buf_b[16];
   int err_total = 0;
   int check_count = 0;
   int n;
   always #5 MCLK = ~MCLK;
   uze_link_if uze_link_if_i ();
   uze_endpoint uze_endpoint_i (.MCLK(MCLK), .RESET_N(RESET_N), .LINK(uze_link_if_i.device_end),
      .USB_RX_VALID(ev[0]), .USB_RX_DATA(rx_data), .USB_RX_PACKET_GOOD(ev[1]), .USB_TX_POP(ev[2]),
      .USB_TX_DATA(tx_data), .USB_TX_PACKET_ACKED(ev[3]), .USB_TRANSFER_END(ev[4]),
      .USB_PROTOCOL_ERROR(ev[5]), .USB_STALL(stall), .USB_TX_READY(tx_ready), .USB_RX_READY(rx_ready),
      .USB_FIFO_LEVEL(level), .USB_MAX_PACKET(maxp));
   uze_controller uze_controller_i (.MCLK(MCLK), .RESET_N(RESET_N), .LINK(uze_link_if_i.cpu_end),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
      .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .IRQ(irq_pin));
   uze_link_monitor uze_link_monitor_i (.MCLK(MCLK), .RESET_N(RESET_N), .req_write(uze_link_if_i.req_write),
      .req_read(uze_link_if_i.req_read), .req_addr(uze_link_if_i.req_addr), .req_wdata(uze_link_if_i.req_wdata),
      .rsp_valid(uze_link_if_i.rsp_valid), .rsp_rdata(uze_link_if_i.rsp_rdata), .irq(uze_link_if_i.irq));
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      check_count++;
      if (got !== want) begin
         err_total++;
         $display("[FAIL] %0t got %h want %h", $time, got, want);
      end
   endtask : chk
   task automatic summarize();
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   // Waitrequest is taken at the rising edge itself, before that edge's updates land
   task automatic avs(input logic rd, input logic [3:0] a, input logic [31:0] d, input logic [31:0] m);
      logic w;
      int k;
      @(posedge MCLK);
      avs_address <= a;
      avs_read <= rd;
      avs_write <= !rd;
      avs_writedata <= d;
      if (rd) begin
         exp_q.push_back(d & m);
         msk_q.push_back(m);
      end
      k = 0;
      do begin
         @(posedge MCLK);
         w = avs_waitrequest;
         k++;
      end while (w !== 1'b0 && k < 50);
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      chk({31'h0, w}, 32'h0);
   endtask : avs
   task automatic cmd(input logic [2:0] op, input logic [2:0] idx);
      avs(1'b0, `UZE_AVS_CMD, {21'h0, idx, 5'h00, op}, 32'h0);
      repeat (3) @(posedge MCLK);
   endtask : cmd
   task automatic ep_wr(input logic [2:0] idx, input logic [31:0] d);
      avs(1'b0, `UZE_AVS_WDATA, d, 32'h0);
      cmd(`UZE_OP_WRITE, idx);
   endtask : ep_wr
   task automatic ep_rd(input logic [2:0] idx, input logic [31:0] want);
      cmd(`UZE_OP_READ, idx);
      avs(1'b1, `UZE_AVS_RDATA, want, 32'hFFFFFFFF);
   endtask : ep_rd
   task automatic eng(input logic [5:0] v, input logic [7:0] d);
      @(posedge MCLK);
      ev <= v;
      rx_data <= d;
      @(posedge MCLK);
      ev <= 6'h00;
      @(negedge MCLK);
   endtask : eng
   task automatic rx_bytes(input int cnt);
      for (int i = 0; i < cnt; i++) begin
         buf_b[i] = 8'($urandom);
         eng(ev_rx, buf_b[i]);
      end
   endtask : rx_bytes
   always @(negedge MCLK) begin
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
         if (exp_q.size() == 0) begin
            chk(32'h1, 32'h0);
         end else begin
            chk(avs_readdata & msk_q.pop_front(), exp_q.pop_front());
         end
      end
   end
   initial begin
      #300000;
      err_total++;
      summarize();
   end
   initial begin
      void'($urandom(32'hBF66));
      repeat (6) @(posedge MCLK);
      RESET_N <= 1'b1;
      ep_rd(0, 32'h0);
      ep_rd(1, 32'h1);
      ep_rd(5, 32'h1);
      ep_rd(6, 32'h0);
      for (int c = 0; c < 4; c++) begin
         ep_wr(1, (32'($urandom) & 32'hFFFFFFFC) | 32'(c));
         chk(maxp, c == 1 ? 32'h8 : c == 2 ? 32'h10 : 32'h0);
         ep_rd(1, 32'(c));
      end
      n = 1 + ($urandom % 16);
      rx_bytes(n);
      eng(ev_good, 8'h00);
      chk(rx_ready, 32'h1);
      avs(1'b1, `UZE_AVS_STATUS, 32'h0, 32'h3);
      ep_wr(5, 32'h0);
      avs(1'b1, `UZE_AVS_STATUS, 32'h2, 32'h3);
      chk({31'h0, irq_pin}, 32'h1);
      ep_rd(2, 32'(n));
      for (int i = 0; i < n; i++) ep_rd(3, 32'(buf_b[i]));
      ep_rd(3, 32'h0);
      cmd(`UZE_OP_FINISH_RX, 0);
      @(negedge MCLK);
      chk(rx_ready, 32'h0);
      ep_rd(0, 32'h08);
      eng(ev_end, 8'h00);
      ep_rd(0, 32'h0);
      ep_wr(4, 32'h1);
      avs(1'b1, `UZE_AVS_STATUS, 32'h0, 32'h3);
      chk({31'h0, irq_pin}, 32'h0);
      n = 1 + ($urandom % 8);
      for (int i = 0; i < n; i++) begin
         buf_b[i] = 8'($urandom);
         ep_wr(3, {24'($urandom), buf_b[i]});
      end
      @(negedge MCLK);
      chk(level, 32'(n));
      cmd(`UZE_OP_FINISH_TX, 0);
      ep_rd(0, 32'h0A);
      for (int i = 0; i < n; i++) begin
         eng(ev_pop, 8'h00);
         chk(tx_data, 32'(buf_b[i]));
      end
      eng(ev_ack, 8'h00);
      chk(tx_ready, 32'h0);
      avs(1'b1, `UZE_AVS_STATUS, 32'h2, 32'h3);
      eng(ev_end, 8'h00);
      ep_wr(4, 32'h1);
      rx_bytes(3);
      eng(ev_end, 8'h00);
      chk(level, 32'h0);
      ep_rd(0, 32'h10);
      ep_wr(3, 32'h5A);
      @(negedge MCLK);
      chk(level, 32'h0);
      ep_rd(3, 32'h0);
      cmd(`UZE_OP_SVC_SETUP, 0);
      ep_rd(0, 32'h0);
      eng(ev_good, 8'h00);
      cmd(`UZE_OP_REJECT, 0);
      @(negedge MCLK);
      chk({stall, rx_ready}, 32'h2);
      ep_wr(0, 32'h0);
      @(negedge MCLK);
      chk(stall, 32'h0);
      eng(ev_err, 8'h00);
      ep_rd(0, 32'h04);
      cmd(`UZE_OP_FINISH_TX, 0);
      ep_rd(0, 32'h0E);
      ep_wr(0, 32'h0);
      ep_rd(0, 32'h0A);
      eng(ev_ack, 8'h00);
      eng(ev_end, 8'h00);
      cmd(`UZE_OP_SEND_TX, 0);
      ep_rd(0, 32'h02);
      chk(32'(exp_q.size()), 32'h0);
      summarize();
   end
endmodule : test_usb_control_endpoint_zero

// ---- uze_controller.sv ----
`include "uze_defines.svh"
module uze_controller (
   input wire logic MCLK,                 // System clock
   input wire logic RESET_N,              // Asynchronous reset, active low
   uze_link_if.cpu_end LINK,              // Register access toward the endpoint
   input wire logic [3:0] AVS_ADDRESS,    // Avalon byte address
   input wire logic AVS_READ,             // Avalon read
   input wire logic AVS_WRITE,            // Avalon write
   input wire logic [31:0] AVS_WRITEDATA, // Avalon write data
   output logic [31:0] AVS_READDATA,      // Avalon read data
   output logic AVS_WAITREQUEST,          // Avalon wait request
   output logic IRQ                       // Endpoint interrupt passed through
);
   uze_pkg::uze_ctl_state_type s;
   uze_pkg::uze_ctl_state_type next_s;

   logic cmd_hit, busy;
   logic [2:0] op;
   logic [31:0] idx_addr;

   assign busy = s.phase != uze_pkg::UZE_IDLE;
   assign cmd_hit = AVS_WRITE && AVS_ADDRESS == `UZE_AVS_CMD;
   // A command is held off while one is still on the link
   assign AVS_WAITREQUEST = (cmd_hit && busy) || (AVS_READ && !s.rd_ack);

   always_comb begin
      next_s = s;
      next_s.req_write = 1'b0;
      next_s.req_read = 1'b0;
      next_s.rd_ack = 1'b0;
      op = AVS_WRITEDATA[`UZE_CMD_OP];
      idx_addr = `UZE_REG_BASE + {27'h0000000, AVS_WRITEDATA[`UZE_CMD_IDX], 2'h0};
      if (AVS_WRITE && AVS_ADDRESS == `UZE_AVS_WDATA) next_s.wdata = AVS_WRITEDATA;
      if (AVS_READ && !s.rd_ack) begin
         next_s.rd_ack = 1'b1;
         unique case (AVS_ADDRESS)
            `UZE_AVS_WDATA: next_s.readdata = s.wdata;
            `UZE_AVS_RDATA: next_s.readdata = s.rdata;
            `UZE_AVS_STATUS: next_s.readdata = {30'h00000000, LINK.irq, busy};
            default: next_s.readdata = 32'h00000000;
         endcase
      end
      unique case (s.phase)
         uze_pkg::UZE_IDLE: begin
            if (cmd_hit && op != 3'h0) begin
               next_s.phase = uze_pkg::UZE_WAIT;
               next_s.req_addr = `UZE_CSR_ADDR;
               next_s.req_wdata = 32'h00000000;
               next_s.req_write = 1'b1;
               unique case (op)
                  `UZE_OP_WRITE: begin
                     next_s.req_addr = idx_addr;
                     next_s.req_wdata = s.wdata;
                  end
                  `UZE_OP_READ: begin
                     next_s.req_addr = idx_addr;
                     next_s.req_write = 1'b0;
                     next_s.req_read = 1'b1;
                  end
                  `UZE_OP_FINISH_TX: begin
                     next_s.req_wdata[`UZE_BIT_TX_READY] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_DATA_END] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_SENT_STALL] = 1'b1;
                  end
                  `UZE_OP_FINISH_RX: begin
                     next_s.req_wdata[`UZE_BIT_SVC_RX] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_DATA_END] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_SENT_STALL] = 1'b1;
                  end
                  `UZE_OP_REJECT: begin
                     next_s.req_wdata[`UZE_BIT_SVC_RX] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_STALL] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_SENT_STALL] = 1'b1;
                  end
                  `UZE_OP_SVC_SETUP: begin
                     next_s.req_wdata[`UZE_BIT_SVC_SETUP] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_SENT_STALL] = 1'b1;
                  end
                  default: begin
                     next_s.req_wdata[`UZE_BIT_TX_READY] = 1'b1;
                     next_s.req_wdata[`UZE_BIT_SENT_STALL] = 1'b1;
                  end
               endcase
            end
         end
         uze_pkg::UZE_WAIT: begin
            if (LINK.rsp_valid) begin
               next_s.rdata = LINK.rsp_rdata;
               next_s.phase = uze_pkg::UZE_IDLE;
            end
         end
         default: next_s.phase = uze_pkg::UZE_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s <= '0;
         s.phase <= uze_pkg::UZE_IDLE;
      end else begin
         s <= next_s;
      end
   end

   assign LINK.req_write = s.req_write;
   assign LINK.req_read = s.req_read;
   assign LINK.req_addr = s.req_addr;
   assign LINK.req_wdata = s.req_wdata;
   assign AVS_READDATA = s.readdata;
   assign IRQ = LINK.irq;
endmodule : uze_controller

// ---- uze_defines.svh ----
`ifndef UZE_DEFINES_SVH
`define UZE_DEFINES_SVH

// Register map of the endpoint, reached over the link
`define UZE_CSR_ADDR 32'h15200160
`define UZE_MAXP_ADDR 32'h15200164
`define UZE_COUNT_ADDR 32'h15200168
`define UZE_FIFO_ADDR 32'h1520016C
`define UZE_PEND_ADDR 32'h15200170
`define UZE_MASK_ADDR 32'h15200174
`define UZE_REG_BASE 32'h15200160

// Control/status bit positions
`define UZE_BIT_SVC_SETUP 7
`define UZE_BIT_SVC_RX 6
`define UZE_BIT_STALL 5
`define UZE_BIT_SETUP_END 4
`define UZE_BIT_DATA_END 3
`define UZE_BIT_SENT_STALL 2
`define UZE_BIT_TX_READY 1
`define UZE_BIT_RX_READY 0

// Endpoint FIFO and packet sizes
`define UZE_FIFO_WORDS 16
`define UZE_FIFO_FULL 5'h10
`define UZE_MAXP_CODE_0 2'h0
`define UZE_MAXP_CODE_8 2'h1
`define UZE_MAXP_CODE_16 2'h2
`define UZE_MAXP_BYTES_8 5'h08
`define UZE_MAXP_BYTES_16 5'h10
`define UZE_MAXP_RESET 2'h1
`define UZE_MASK_RESET 1'h1

// Controller registers on the Avalon side (byte offsets)
`define UZE_AVS_CMD 4'h0
`define UZE_AVS_WDATA 4'h4
`define UZE_AVS_RDATA 4'h8
`define UZE_AVS_STATUS 4'hC

// Controller command encoding
`define UZE_CMD_OP 2:0
`define UZE_CMD_IDX 10:8
`define UZE_OP_WRITE 3'h1
`define UZE_OP_READ 3'h2
`define UZE_OP_FINISH_TX 3'h3
`define UZE_OP_FINISH_RX 3'h4
`define UZE_OP_REJECT 3'h5
`define UZE_OP_SVC_SETUP 3'h6
`define UZE_OP_SEND_TX 3'h7
`endif

// ---- uze_endpoint.sv ----
// Local design decision: the link interface to the registers.
`include "uze_defines.svh"
module uze_endpoint (
   input wire logic MCLK,                 // System clock
   input wire logic RESET_N,              // Asynchronous reset, active low
   uze_link_if.device_end LINK,           // Register access from the processor side
   input wire logic USB_RX_VALID,         // Received byte strobe from the serial engine
   input wire logic [7:0] USB_RX_DATA,    // Received byte
   input wire logic USB_RX_PACKET_GOOD,   // Received packet ended with good checks
   input wire logic USB_TX_POP,           // Serial engine takes the next byte
   output logic [7:0] USB_TX_DATA,        // Byte taken by the previous pop
   input wire logic USB_TX_PACKET_ACKED,  // Host acknowledged the sent packet
   input wire logic USB_TRANSFER_END,     // Control transfer finished or was cut short
   input wire logic USB_PROTOCOL_ERROR,   // Transaction aborted by a protocol violation
   output logic USB_STALL,                // Answer the control transfer with STALL
   output logic USB_TX_READY,             // A packet waits in the FIFO for the host
   output logic USB_RX_READY,             // Received packet not yet serviced
   output logic [4:0] USB_FIFO_LEVEL,     // Bytes held in the FIFO
   output logic [4:0] USB_MAX_PACKET      // Packet size in bytes
);
   uze_pkg::uze_dev_state_type s;
   uze_pkg::uze_dev_state_type next_s;

   logic hit_csr, hit_maxp, hit_count, hit_fifo, hit_pend, hit_mask;
   logic setup_evt, end_evt, irq_evt, fifo_open;
   logic push, pop, push_usb, pop_usb, pop_cpu;
   logic [7:0] push_data;
   logic [31:0] wd;

   always_comb begin
      next_s = s;
      next_s.rsp_valid = 1'b0;
      wd = LINK.req_wdata;
      hit_csr = LINK.req_addr == `UZE_CSR_ADDR;
      hit_maxp = LINK.req_addr == `UZE_MAXP_ADDR;
      hit_count = LINK.req_addr == `UZE_COUNT_ADDR;
      hit_fifo = LINK.req_addr == `UZE_FIFO_ADDR;
      hit_pend = LINK.req_addr == `UZE_PEND_ADDR;
      hit_mask = LINK.req_addr == `UZE_MASK_ADDR;
      setup_evt = USB_TRANSFER_END && !s.data_end;
      end_evt = USB_TRANSFER_END && s.data_end;
      irq_evt = 1'b0;
      fifo_open = !s.setup_end;

      // Processor writes first, so that engine events below win over clears
      if (LINK.req_write) begin
         next_s.rsp_valid = 1'b1;
         if (hit_csr) begin
            if (wd[`UZE_BIT_SVC_SETUP]) next_s.setup_end = 1'b0;
            if (wd[`UZE_BIT_SVC_RX]) begin
               next_s.rx_ready = 1'b0;
               next_s.rx_count = 5'h00;
            end
            next_s.stall = wd[`UZE_BIT_STALL];
            if (wd[`UZE_BIT_DATA_END]) next_s.data_end = 1'b1;
            if (!wd[`UZE_BIT_SENT_STALL]) next_s.sent_stall = 1'b0;
            if (wd[`UZE_BIT_TX_READY]) next_s.tx_ready = 1'b1;
         end
         if (hit_maxp) next_s.max_code = wd[1:0];
         if (hit_count) next_s.rx_count = wd[4:0];
         if (hit_mask) next_s.mask = wd[0];
         if (hit_pend && wd[0]) next_s.pending = 1'b0;
      end

      // FIFO: one push and one pop per cycle; the engine has priority
      push_usb = USB_RX_VALID && s.level != `UZE_FIFO_FULL;
      push = push_usb || (LINK.req_write && hit_fifo && fifo_open && !USB_RX_VALID
             && s.level != `UZE_FIFO_FULL);
      push_data = USB_RX_VALID ? USB_RX_DATA : wd[7:0];
      pop_usb = USB_TX_POP && s.level != 5'h00;
      pop_cpu = LINK.req_read && hit_fifo && fifo_open && !USB_TX_POP && s.level != 5'h00;
      pop = pop_usb || pop_cpu;
      if (push) begin
         next_s.mem[s.wr_ptr] = push_data;
         next_s.wr_ptr = s.wr_ptr + 4'h1;
      end
      if (pop) next_s.rd_ptr = s.rd_ptr + 4'h1;
      if (pop_usb) next_s.tx_byte = s.mem[s.rd_ptr];
      next_s.level = s.level + {4'h0, push} - {4'h0, pop};
      if (push_usb) next_s.rx_count = s.rx_count + 5'h01;

      // Engine events
      if (USB_TX_PACKET_ACKED && s.tx_ready) begin
         next_s.tx_ready = 1'b0;
         irq_evt = 1'b1;
      end
      if (USB_RX_PACKET_GOOD) begin
         next_s.rx_ready = 1'b1;
         irq_evt = 1'b1;
      end
      if (USB_PROTOCOL_ERROR) begin
         next_s.sent_stall = 1'b1;
         irq_evt = 1'b1;
      end
      if (end_evt) begin
         next_s.data_end = 1'b0;
         next_s.stall = 1'b0;
         irq_evt = 1'b1;
      end
      if (setup_evt) begin
         next_s.setup_end = 1'b1;
         next_s.stall = 1'b0;
         next_s.wr_ptr = 4'h0;
         next_s.rd_ptr = 4'h0;
         next_s.level = 5'h00;
         irq_evt = 1'b1;
      end
      if (irq_evt) next_s.pending = 1'b1;

      // Read answers; reserved bits stay zero
      if (LINK.req_read) begin
         next_s.rsp_valid = 1'b1;
         next_s.rdata = 32'h00000000;
         if (hit_csr) next_s.rdata[7:0] = {2'h0, s.stall, s.setup_end, s.data_end,
                                           s.sent_stall, s.tx_ready, s.rx_ready};
         if (hit_maxp) next_s.rdata[1:0] = s.max_code;
         if (hit_count) next_s.rdata[4:0] = s.rx_count;
         if (pop_cpu) next_s.rdata[7:0] = s.mem[s.rd_ptr];
         if (hit_pend) next_s.rdata[0] = s.pending;
         if (hit_mask) next_s.rdata[0] = s.mask;
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         s <= '0;
         s.max_code <= `UZE_MAXP_RESET;
         s.mask <= `UZE_MASK_RESET;
      end else begin
         s <= next_s;
      end
   end

   always_comb begin
      unique case (s.max_code)
         `UZE_MAXP_CODE_8: USB_MAX_PACKET = `UZE_MAXP_BYTES_8;
         `UZE_MAXP_CODE_16: USB_MAX_PACKET = `UZE_MAXP_BYTES_16;
         default: USB_MAX_PACKET = 5'h00;
      endcase
   end

   assign LINK.rsp_valid = s.rsp_valid;
   assign LINK.rsp_rdata = s.rdata;
   assign LINK.irq = s.pending && !s.mask;
   assign USB_TX_DATA = s.tx_byte;
   assign USB_STALL = s.stall;
   assign USB_TX_READY = s.tx_ready;
   assign USB_RX_READY = s.rx_ready;
   assign USB_FIFO_LEVEL = s.level;
endmodule : uze_endpoint

// ---- uze_link_if.sv ----
interface uze_link_if;
   logic req_write;
   logic req_read;
   logic [31:0] req_addr;
   logic [31:0] req_wdata;
   logic rsp_valid;
   logic [31:0] rsp_rdata;
   logic irq;

   modport device_end (input req_write, input req_read, input req_addr, input req_wdata,
                       output rsp_valid, output rsp_rdata, output irq);
   modport cpu_end (output req_write, output req_read, output req_addr, output req_wdata,
                    input rsp_valid, input rsp_rdata, input irq);
endinterface : uze_link_if

// ---- uze_link_monitor.sv ----
`include "uze_defines.svh"
module uze_link_monitor (
   input wire logic MCLK,              // System clock
   input wire logic RESET_N,           // Asynchronous reset, active low
   input wire logic req_write,         // Write request
   input wire logic req_read,          // Read request
   input wire logic [31:0] req_addr,   // Register address
   input wire logic [31:0] req_wdata,  // Write data
   input wire logic rsp_valid,         // Answer strobe
   input wire logic [31:0] rsp_rdata,  // Read data
   input wire logic irq                // Endpoint interrupt
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (!RESET_N);
   property p_write_answer; req_write |=> rsp_valid ##1 !rsp_valid; endproperty
   a_write_answer: assert property (p_write_answer) else $error("write answer late");
   property p_read_answer; req_read |=> rsp_valid; endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer late");
   property p_no_spurious; !req_write && !req_read |=> !rsp_valid; endproperty
   a_no_spurious: assert property (p_no_spurious) else $error("answer without request");
   property p_one_dir; !(req_write && req_read); endproperty
   a_one_dir: assert property (p_one_dir) else $error("read and write together");
   property p_csr_reserved; req_read && req_addr == `UZE_CSR_ADDR |=> rsp_rdata[31:6] == 26'h0; endproperty
   a_csr_reserved: assert property (p_csr_reserved) else $error("status reserved bits set");
   property p_maxp_reserved; req_read && req_addr == `UZE_MAXP_ADDR |=> rsp_rdata[31:2] == 30'h0; endproperty
   a_maxp_reserved: assert property (p_maxp_reserved) else $error("max packet reserved bits set");
   property p_count_reserved; req_read && req_addr == `UZE_COUNT_ADDR |=> rsp_rdata[31:5] == 27'h0; endproperty
   a_count_reserved: assert property (p_count_reserved) else $error("count reserved bits set");
   property p_fifo_reserved; req_read && req_addr == `UZE_FIFO_ADDR |=> rsp_rdata[31:8] == 24'h0; endproperty
   a_fifo_reserved: assert property (p_fifo_reserved) else $error("fifo reserved bits set");
   property p_mask_quiet; req_write && req_addr == `UZE_MASK_ADDR && req_wdata[0] |=> !irq; endproperty
   a_mask_quiet: assert property (p_mask_quiet) else $error("masked interrupt still raised");
   c_write: cover property (req_write && req_addr == `UZE_CSR_ADDR);
   c_fifo_read: cover property (req_read && req_addr == `UZE_FIFO_ADDR);
   c_irq: cover property ($rose(irq));
endmodule : uze_link_monitor

// ---- uze_pkg.sv ----
`include "uze_defines.svh"
package uze_pkg;
   typedef struct packed {
      logic setup_end;
      logic stall;
      logic data_end;
      logic sent_stall;
      logic tx_ready;
      logic rx_ready;
      logic [1:0] max_code;
      logic [4:0] rx_count;
      logic [`UZE_FIFO_WORDS-1:0][7:0] mem;
      logic [3:0] wr_ptr;
      logic [3:0] rd_ptr;
      logic [4:0] level;
      logic pending;
      logic mask;
      logic [31:0] rdata;
      logic rsp_valid;
      logic [7:0] tx_byte;
   } uze_dev_state_type;

   typedef enum logic [1:0] {
      UZE_IDLE = 2'h1,
      UZE_WAIT = 2'h2
   } uze_ctl_phase_type;

   typedef struct packed {
      uze_ctl_phase_type phase;
      logic req_write;
      logic req_read;
      logic [31:0] req_addr;
      logic [31:0] req_wdata;
      logic [31:0] wdata;
      logic [31:0] rdata;
      logic [31:0] readdata;
      logic rd_ack;
   } uze_ctl_state_type;
endpackage : uze_pkg
